/* File: hw/cbt_defines.svh */
// constants for the bus timing and power mode block
`ifndef CBT_DEFINES_SVH
`define CBT_DEFINES_SVH
`define CBT_ADDR_BTR0 8'h02
`define CBT_ADDR_CTL0 8'h00
`define CBT_ADDR_CTL1 8'h01
`define CBT_ADDR_CTL1_CFG 8'h03
`define CBT_BTR0_RESET 8'h00
`define CBT_SJW_MSB 7
`define CBT_SJW_LSB 6
`define CBT_BRP_MSB 5
`define CBT_BRP_LSB 0
`define CBT_CTL0_INIT_REQUEST 0
`define CBT_CTL0_SLEEP_REQUEST 1
`define CBT_CTL0_WAKEUP_ENABLE 2
`define CBT_CTL0_STOP_IN_WAIT 3
`define CBT_CTL1_INIT_ACKNOWLEDGE 0
`define CBT_CTL1_SLEEP_ACKNOWLEDGE 1
`define CBT_CTL1_ENABLE 7
`define CBT_CTL0_RESET 8'h01
`define CBT_CTL1_CFG_RESET 8'h80
`endif

/* File: hw/cbt_pkg.sv */
// types for the bus timing and power mode block
package cbt_pkg;
	typedef enum logic [2:0] {
		CBT_NORMAL = 3'b000,
		CBT_SLEEP = 3'b001,
		CBT_POWER_DOWN = 3'b010,
		CBT_DISABLED = 3'b011
	} cbt_mode_e;
	typedef enum logic [1:0] {
		CBT_CPU_RUN = 2'b00,
		CBT_CPU_WAIT = 2'b01,
		CBT_CPU_STOP = 2'b10
	} cbt_cpu_e;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cbt_bus_s;
	typedef struct packed {
		logic [1:0] resync_jump_width;
		logic [5:0] quantum_prescaler;
	} cbt_btr0_s;
endpackage

/* File: hw/cbt_quantum_div.sv */
// divider that makes the time quantum enable pulse
module cbt_quantum_div (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic run_in,
	input wire logic [5:0] quantum_prescaler_in,
	// pulse
	output logic tq_pulse_out
);
	logic [5:0] count;
	wire logic at_end;
	assign at_end = (count >= quantum_prescaler_in);
	// prescaler plus one cycles per quantum, so zero divides by one
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || !run_in) begin
			count <= 6'h00;
			tq_pulse_out <= 1'b0;
		end else begin
			count <= at_end ? 6'h00 : count + 6'h01;
			tq_pulse_out <= at_end;
		end
	end
endmodule

/* File: hw/cbt_sync.sv */
// two flip-flop synchroniser for pin inputs
module cbt_sync (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// data
	input wire logic d_in,
	output logic q_out
);
	logic meta;
	// first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta <= 1'b1;
			q_out <= 1'b1;
		end else begin
			meta <= d_in;
			q_out <= meta;
		end
	end
endmodule

/* File: hw/cbt_top.sv */
// bus timing register and low power mode control
//
// Design decision made here: the address-and-strobe port.
`include "cbt_defines.svh"
module cbt_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// register port
	input wire cbt_pkg::cbt_bus_s bus_in,
	output logic [7:0] rdata_out,
	// cpu mode
	input wire cbt_pkg::cbt_cpu_e cpu_mode_in,
	// can receive pin, recessive high
	input wire logic can_rx_in,
	// status
	output cbt_pkg::cbt_mode_e mode_out,
	output logic [1:0] resync_jump_width_out,
	output logic [2:0] sjw_quanta_out,
	output logic tq_pulse_out,
	output logic clocks_on_out
);
	import cbt_pkg::*;

	cbt_btr0_s bus_bit_timing_first;
	logic init_request, sleep_request, wakeup_enable, stop_in_wait;
	logic module_enable_bit;
	logic init_acknowledge, sleep_acknowledge;
	cbt_mode_e mode;
	logic rx_prev;
	wire logic rx_sync;
	wire logic tq_raw;
	wire logic in_init;
	wire logic wr_btr0, wr_ctl0, wr_cfg;
	wire logic bus_edge;
	wire logic force_pd;
	wire logic asleep;
	cbt_mode_e next_mode;
	logic [7:0] next_rdata;

	cbt_sync u_rx_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(can_rx_in),
		.q_out(rx_sync)
	);

	cbt_quantum_div u_div (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.run_in(mode == CBT_NORMAL),
		.quantum_prescaler_in(bus_bit_timing_first.quantum_prescaler),
		.tq_pulse_out(tq_raw)
	);

	// handshake decode and write gating
	assign in_init = init_request && init_acknowledge;
	assign wr_btr0 = bus_in.wr && bus_in.addr == `CBT_ADDR_BTR0 && in_init;
	assign wr_ctl0 = bus_in.wr && bus_in.addr == `CBT_ADDR_CTL0;
	// enable is always writable, otherwise the module could never leave disabled
	assign wr_cfg = bus_in.wr && bus_in.addr == `CBT_ADDR_CTL1_CFG;
	assign bus_edge = rx_prev && !rx_sync; // dominant edge on the bus
	// wait with stop_in_wait, or stop, forces power down
	assign force_pd = (cpu_mode_in == CBT_CPU_STOP) ||
		(cpu_mode_in == CBT_CPU_WAIT && stop_in_wait);
	assign asleep = sleep_request && sleep_acknowledge;

	// mode selection, disable has top priority
	always_comb begin
		next_mode = mode;
		if (!module_enable_bit) begin
			next_mode = CBT_DISABLED;
		end else if (force_pd) begin
			next_mode = CBT_POWER_DOWN;
		end else begin
			unique case (mode)
				CBT_DISABLED: next_mode = CBT_NORMAL;
				CBT_POWER_DOWN: next_mode = CBT_NORMAL;
				CBT_NORMAL: next_mode = asleep ? CBT_SLEEP : CBT_NORMAL;
				CBT_SLEEP: next_mode = asleep ? CBT_SLEEP : CBT_NORMAL;
				default: next_mode = CBT_DISABLED;
			endcase
		end
	end

	// read mux, timing register readable anytime
	always_comb begin
		next_rdata = 8'h00;
		unique case (bus_in.addr)
			`CBT_ADDR_BTR0: next_rdata = bus_bit_timing_first;
			`CBT_ADDR_CTL0: next_rdata = {4'h0, stop_in_wait, wakeup_enable,
				sleep_request, init_request};
			`CBT_ADDR_CTL1: next_rdata = {module_enable_bit, 5'h00,
				sleep_acknowledge, init_acknowledge};
			`CBT_ADDR_CTL1_CFG: next_rdata = {module_enable_bit, 7'h00};
			default: next_rdata = 8'h00;
		endcase
	end

	// control register and timing register
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			bus_bit_timing_first <= `CBT_BTR0_RESET;
			init_request <= 1'b1;
			sleep_request <= 1'b0;
			wakeup_enable <= 1'b0;
			stop_in_wait <= 1'b0;
			module_enable_bit <= 1'b1;
		end else begin
			if (wr_btr0) begin
				bus_bit_timing_first <= bus_in.wdata;
			end
			if (wr_ctl0) begin
				init_request <= bus_in.wdata[`CBT_CTL0_INIT_REQUEST];
				sleep_request <= bus_in.wdata[`CBT_CTL0_SLEEP_REQUEST];
				wakeup_enable <= bus_in.wdata[`CBT_CTL0_WAKEUP_ENABLE];
				stop_in_wait <= bus_in.wdata[`CBT_CTL0_STOP_IN_WAIT];
			end else if (mode == CBT_SLEEP && wakeup_enable && bus_edge) begin
				sleep_request <= 1'b0; // wake drops the request too
			end
			if (wr_cfg) begin
				module_enable_bit <= bus_in.wdata[`CBT_CTL1_ENABLE];
			end
		end
	end

	// init acknowledge follows its request one cycle later, sleep acknowledge only while enabled and not forced to power down
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			init_acknowledge <= 1'b1;
			sleep_acknowledge <= 1'b0;
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= rx_sync;
			init_acknowledge <= init_request;
			if (mode == CBT_SLEEP && wakeup_enable && bus_edge) begin
				sleep_acknowledge <= 1'b0;
			end else begin
				sleep_acknowledge <= sleep_request && module_enable_bit && !force_pd;
			end
		end
	end

	// mode state and registered outputs
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode <= CBT_NORMAL;
			mode_out <= CBT_NORMAL;
			rdata_out <= 8'h00;
			resync_jump_width_out <= 2'b00;
			sjw_quanta_out <= 3'h1;
			tq_pulse_out <= 1'b0;
			clocks_on_out <= 1'b1;
		end else begin
			mode <= next_mode;
			mode_out <= next_mode;
			rdata_out <= bus_in.rd ? next_rdata : 8'h00;
			resync_jump_width_out <= bus_bit_timing_first.resync_jump_width;
			sjw_quanta_out <= {1'b0, bus_bit_timing_first.resync_jump_width} + 3'h1;
			tq_pulse_out <= tq_raw;
			clocks_on_out <= (next_mode == CBT_NORMAL);
		end
	end
endmodule

/* File: tb/cbt_can_bus.sv */
// can bus model on the receive pin
module cbt_can_bus (
	// clock and line
	input wire logic clk_in,
	output logic can_rx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// recessive high while idle
	initial can_rx_out = 1'b1;
	task automatic send_dominant(input int n);
		@(posedge clk_in);
		can_rx_out <= 1'b0;
		repeat (n) @(posedge clk_in);
		can_rx_out <= 1'b1;
	endtask
endmodule

/* File: tb/cbt_top_sva.sv */
// port checker for the timing and power block
module cbt_top_sva (
	// watched ports
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire cbt_pkg::cbt_bus_s bus_in,
	input wire logic [7:0] rdata_out,
	input wire cbt_pkg::cbt_cpu_e cpu_mode_in,
	input wire cbt_pkg::cbt_mode_e mode_out,
	input wire logic [1:0] resync_jump_width_out,
	input wire logic [2:0] sjw_quanta_out,
	input wire logic tq_pulse_out,
	input wire logic clocks_on_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import cbt_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_sjw; sjw_quanta_out == {1'b0, resync_jump_width_out} + 3'd1; endproperty
	a_sjw: assert property (p_sjw) else $error("jump width");
	property p_idle; !$past(bus_in.rd) |-> rdata_out == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read idle");
	property p_unm; bus_in.rd && bus_in.addr > 8'h03 |=> rdata_out == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped");
	property p_jw; $changed(resync_jump_width_out) |-> $past(bus_in.wr) || $past(bus_in.wr, 2);
	endproperty
	a_jw: assert property (p_jw) else $error("jw change");
	property p_stp; cpu_mode_in == CBT_CPU_STOP |-> ##[1:2] mode_out != CBT_NORMAL; endproperty
	a_stp: assert property (p_stp) else $error("stop");
	property p_pd; mode_out == CBT_POWER_DOWN && cpu_mode_in == CBT_CPU_RUN
		|-> ##[1:3] mode_out != CBT_POWER_DOWN; endproperty
	a_pd: assert property (p_pd) else $error("pd exit");
	// three cycles, since a quantum pulse launched in the last normal cycle still trails by two
	property p_clk; (mode_out != CBT_NORMAL)[*3] |-> !clocks_on_out && !tq_pulse_out; endproperty
	a_clk: assert property (p_clk) else $error("clocks");
	property p_sc; (cpu_mode_in == CBT_CPU_STOP)[*3] |-> !clocks_on_out; endproperty
	a_sc: assert property (p_sc) else $error("stop clocks");
endmodule
bind cbt_top cbt_top_sva i_sva (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus_in),
	.rdata_out(rdata_out), .cpu_mode_in(cpu_mode_in), .mode_out(mode_out),
	.resync_jump_width_out(resync_jump_width_out), .sjw_quanta_out(sjw_quanta_out),
	.tq_pulse_out(tq_pulse_out), .clocks_on_out(clocks_on_out));

/* File: tb/can_bit_timing_power_modes_bench.sv */
// testbench for the timing and power block
module can_bit_timing_power_modes_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import cbt_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	cbt_bus_s bus = '0;
	cbt_cpu_e cpu = CBT_CPU_RUN;
	logic rx;
	logic [7:0] rdat;
	logic [7:0] got;
	cbt_mode_e mode;
	logic [1:0] jw;
	logic [2:0] sq;
	logic tq;
	logic con;
	int err_total = 0;
	int n_tests = 0;
	// 4 ns period
	always #2 clk = ~clk;
	cbt_top i_dut (.clk_in(clk), .rst_n_in(rst_n), .bus_in(bus), .rdata_out(rdat),
		.cpu_mode_in(cpu), .can_rx_in(rx), .mode_out(mode), .resync_jump_width_out(jw),
		.sjw_quanta_out(sq), .tq_pulse_out(tq), .clocks_on_out(con));
	cbt_can_bus i_bus (.clk_in(clk), .can_rx_out(rx));
	task automatic chk(input logic [7:0] a, input logic [7:0] e);
		n_tests++;
		if (a !== e) begin
			err_total++;
			$display("wrong value at %0t: %h not %h", $time, a, e);
		end
	endtask
	// one cycle strobes, released at the following edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 got = rdat;
	endtask
	// modes settle a few cycles after their cause
	task automatic cm(input cbt_mode_e m);
		repeat (4) @(posedge clk);
		#1 chk({5'b0, mode}, {5'b0, m});
		chk({7'b0, con}, {7'b0, m == CBT_NORMAL});
	endtask
	// cpu mode changes right on a rising edge
	task automatic set_cpu(input cbt_cpu_e c);
		@(posedge clk);
		cpu <= c;
	endtask
	task automatic t_jump;
		cm(CBT_NORMAL);
		rd(8'h02);
		chk(got, 8'h00);
		rd(8'h07);
		chk(got, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(8'h02, {c[1:0], 6'h05});
			rd(8'h02);
			chk(got, {c[1:0], 6'h05});
			chk({5'b0, sq}, 8'(c + 1));
			chk({6'b0, jw}, {6'b0, c[1:0]});
		end
	endtask
	// prescaler 5 gives a pulse every 6 cycles
	task automatic t_quantum;
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge clk);
				#1 n++;
			end while (!tq && n < 70);
		end
		chk(8'(n), 8'd6);
	endtask
	task automatic t_lock_sleep;
		wr(8'h00, 8'h00);
		rd(8'h01);
		chk(got, 8'h80);
		wr(8'h02, 8'h3a);
		rd(8'h02);
		chk(got, 8'hc5);
		wr(8'h00, 8'h06);
		cm(CBT_SLEEP);
		rd(8'h01);
		chk(got, 8'h82);
		i_bus.send_dominant(3);
		cm(CBT_NORMAL);
	endtask
	task automatic t_cpu;
		set_cpu(CBT_CPU_WAIT);
		cm(CBT_NORMAL);
		wr(8'h00, 8'h08);
		cm(CBT_POWER_DOWN);
		set_cpu(CBT_CPU_RUN);
		cm(CBT_NORMAL);
		set_cpu(CBT_CPU_STOP);
		cm(CBT_POWER_DOWN);
		set_cpu(CBT_CPU_RUN);
		wr(8'h03, 8'h00);
		set_cpu(CBT_CPU_STOP);
		cm(CBT_DISABLED);
		set_cpu(CBT_CPU_RUN);
		wr(8'h03, 8'h80);
		cm(CBT_NORMAL);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_jump();
		t_quantum();
		t_lock_sleep();
		t_cpu();
		report_and_stop();
	end
	// watchdog well beyond the expected run
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
endmodule
